// ===== logic/sar_adc_pkg.sv
// Constants, register map and types for the SAR converter sequencer.
// Assumes one 25 MHz system clock; the analog comparator sits outside.
package sar_adc_pkg;
  localparam logic [15:0] RESULT_ADDR   = 16'hff18;
  localparam logic [15:0] MODE_ADDR     = 16'hff80;
  localparam logic [15:0] CHANNEL_ADDR  = 16'hff81;
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [2:0]  CHANNEL_RESET = 3'h0;
  localparam int          EN_BIT        = 7;
  localparam int          SRC_BIT       = 6;
  localparam int          TIME_HI       = 5;
  localparam int          TIME_LO       = 3;
  localparam int          EDGE_HI       = 2;
  localparam int          EDGE_LO       = 1;
  localparam int          RES_BITS      = 10;
  localparam int          PAD_BITS      = 6;
  localparam logic [7:0]  CYC_144       = 8'h90;
  localparam logic [7:0]  CYC_120       = 8'h78;
  localparam logic [7:0]  CYC_96        = 8'h60;
  localparam logic [7:0]  CYC_72        = 8'h48;
  localparam logic [7:0]  CYC_60        = 8'h3c;
  localparam logic [7:0]  CYC_48        = 8'h30;
  localparam logic [7:0]  SAMPLE_CYC    = 8'h08;
  localparam logic [1:0]  EDGE_NONE     = 2'h0;
  localparam logic [1:0]  EDGE_FALL     = 2'h1;
  localparam logic [1:0]  EDGE_RISE     = 2'h2;
  localparam logic [1:0]  EDGE_BOTH     = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WAIT   = 2'b01,
    ST_SAMPLE = 2'b10,
    ST_CONV   = 2'b11
  } conv_state_t;
endpackage

// ===== logic/sar_adc_ctrl.sv
// Sequencer for the 10-bit successive-approximation converter.
// Assumes an external comparator answers COMP_I against the tap code DAC_CODE_O.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_ctrl
  import sar_adc_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  input  wire logic [15:0] ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  input  wire logic        TRIGGER_I,
  input  wire logic        COMP_I,
  output logic      [2:0]  CHANNEL_O,
  output logic             HOLD_O,
  output logic      [9:0]  DAC_CODE_O,
  output logic             DONE_IRQ_O,
  output logic             TIME_ERR_O
);

  typedef struct packed {
    logic [7:0]  mode;
    logic [2:0]  chan;
    logic [1:0]  trg_sync;
    logic        trg_prev;
    conv_state_t state;
    logic [9:0]  approx;
    logic [3:0]  bit_idx;
    logic [7:0]  step_cnt;
    logic [7:0]  step_len;
    logic        done;
    logic [15:0] rdata;
  } ctrl_t;

  ctrl_t       ctl_r;
  ctrl_t       ctl_nxt;
  logic [9:0]  result_r;
  logic        load_result;
  logic [7:0]  conv_len;
  logic        time_bad;
  logic        rise;
  logic        fall;
  logic        trig_evt;
  logic        reg_write;
  logic [1:0]  edge_sel;

  always_comb begin
    conv_len = CYC_144;
    time_bad = 1'b0;
    unique case (ctl_r.mode[TIME_HI:TIME_LO])
      3'b000: conv_len = CYC_144;
      3'b001: conv_len = CYC_120;
      3'b010: conv_len = CYC_96;
      3'b100: conv_len = CYC_72;
      3'b101: conv_len = CYC_60;
      3'b110: conv_len = CYC_48;
      default: time_bad = 1'b1;
    endcase
  end

  // Second synchroniser stage and its delayed copy feed the edge detector
  assign rise     = ctl_r.trg_sync[1] & ~ctl_r.trg_prev;
  assign fall     = ~ctl_r.trg_sync[1] & ctl_r.trg_prev;
  assign edge_sel = ctl_r.mode[EDGE_HI:EDGE_LO];
  assign trig_evt = ((edge_sel == EDGE_RISE) & rise) | ((edge_sel == EDGE_FALL) & fall)
                  | ((edge_sel == EDGE_BOTH) & (rise | fall));
  assign reg_write = WR_I & ((ADDR_I == MODE_ADDR) | (ADDR_I == CHANNEL_ADDR));

  always_comb begin
    ctl_nxt          = ctl_r;
    ctl_nxt.done     = 1'b0;
    ctl_nxt.trg_sync = {ctl_r.trg_sync[0], TRIGGER_I};
    ctl_nxt.trg_prev = ctl_r.trg_sync[1];
    load_result      = 1'b0;

    // Sequencing first, so that a register write in the same cycle overrides it
    unique case (ctl_r.state)
      ST_IDLE: begin
        if (ctl_r.mode[EN_BIT]) begin
          if (ctl_r.mode[SRC_BIT]) begin
            ctl_nxt.state = ST_WAIT;
          end else begin
            ctl_nxt.state    = ST_SAMPLE;
            ctl_nxt.step_cnt = SAMPLE_CYC;
          end
        end
      end
      ST_WAIT: begin
        if (trig_evt) begin
          ctl_nxt.state    = ST_SAMPLE;
          ctl_nxt.step_cnt = SAMPLE_CYC;
        end
      end
      ST_SAMPLE: begin
        ctl_nxt.step_cnt = ctl_r.step_cnt - 8'h01;
        if (ctl_r.step_cnt == 8'h01) begin
          // Step length leaves the sample window out of the total time
          ctl_nxt.step_len = 8'((conv_len - SAMPLE_CYC) / 8'(RES_BITS));
          ctl_nxt.step_cnt = 8'((conv_len - SAMPLE_CYC) / 8'(RES_BITS));
          ctl_nxt.bit_idx  = 4'(RES_BITS - 1);
          ctl_nxt.approx   = 10'h200;
          ctl_nxt.state    = ST_CONV;
        end
      end
      ST_CONV: begin
        ctl_nxt.step_cnt = ctl_r.step_cnt - 8'h01;
        if (ctl_r.step_cnt == 8'h01) begin
          ctl_nxt.step_cnt = ctl_r.step_len;
          ctl_nxt.approx[ctl_r.bit_idx] = COMP_I;
          if (ctl_r.bit_idx != 4'h0) begin
            ctl_nxt.bit_idx = ctl_r.bit_idx - 4'h1;
            ctl_nxt.approx[ctl_r.bit_idx - 4'h1] = 1'b1;
          end else begin
            load_result  = 1'b1;
            ctl_nxt.done = 1'b1;
            if (ctl_r.mode[SRC_BIT]) begin
              ctl_nxt.state = ST_WAIT;
            end else begin
              ctl_nxt.state    = ST_SAMPLE;
              ctl_nxt.step_cnt = SAMPLE_CYC;
            end
          end
        end
      end
    endcase

    if (!ctl_r.mode[EN_BIT]) begin
      ctl_nxt.state = ST_IDLE;
    end

    // Any control write restarts the sequence from idle
    if (reg_write) begin
      ctl_nxt.state = ST_IDLE;
      ctl_nxt.done  = 1'b0;
      load_result   = 1'b0;
    end
    if (WR_I && ADDR_I == MODE_ADDR) begin
      ctl_nxt.mode = {WDATA_I[7:1], 1'b0};
    end
    if (WR_I && ADDR_I == CHANNEL_ADDR) begin
      ctl_nxt.chan = WDATA_I[2:0];
    end

    ctl_nxt.rdata = 16'h0000;
    if (RD_I) begin
      unique case (ADDR_I)
        RESULT_ADDR:  ctl_nxt.rdata = {result_r, {PAD_BITS{1'b0}}};
        MODE_ADDR:    ctl_nxt.rdata = {8'h00, ctl_r.mode};
        CHANNEL_ADDR: ctl_nxt.rdata = {13'h0000, ctl_r.chan};
        default:      ctl_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctl_r          <= '0;
      ctl_r.mode     <= MODE_RESET;
      ctl_r.chan     <= CHANNEL_RESET;
      ctl_r.state    <= ST_IDLE;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // No reset on the result, so it holds whatever it held before
  always_ff @(posedge REF_CLK_I) begin
    if (load_result) begin
      result_r <= ctl_r.approx;
    end
  end

  assign RDATA_O    = ctl_r.rdata;
  assign CHANNEL_O  = ctl_r.chan;
  assign HOLD_O     = (ctl_r.state == ST_CONV);
  assign DAC_CODE_O = ctl_r.approx;
  assign DONE_IRQ_O = ctl_r.done;
  assign TIME_ERR_O = time_bad & ctl_r.mode[EN_BIT];
endmodule // sar_adc_ctrl
`default_nettype wire

// ===== verif/sar_adc_checker.sv
// Port assertions for the converter sequencer.
// Assumes binding into sar_adc_ctrl; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module sar_adc_checker
  import sar_adc_pkg::*;
(
  input wire logic        REF_CLK_I,
  input wire logic        RST_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic        HOLD_O,
  input wire logic [9:0]  DAC_CODE_O,
  input wire logic        DONE_IRQ_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  chk_done_one_pulse: assert property (DONE_IRQ_O |=> !DONE_IRQ_O)
    else $error("done pulse too long");
  chk_result_pad_zero: assert property ((RD_I && ADDR_I == RESULT_ADDR)
    |=> RDATA_O[5:0] == 6'h00) else $error("result low bits not zero");
  chk_read_idle_zero: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data without read");
  chk_msb_first_trial: assert property ($rose(HOLD_O) |-> DAC_CODE_O == 10'h200)
    else $error("first trial not bit 9");
  chk_done_ends_hold: assert property (DONE_IRQ_O |-> $fell(HOLD_O))
    else $error("done without end of hold");
  chk_hold_steady: assert property (HOLD_O && !WR_I |=> HOLD_O || DONE_IRQ_O)
    else $error("hold dropped early");
  chk_stop_on_clear: assert property ((WR_I && ADDR_I == MODE_ADDR && !WDATA_I[EN_BIT])
    |=> !HOLD_O [*8]) else $error("runs while disabled");
  chk_write_aborts: assert property ((WR_I && ADDR_I == CHANNEL_ADDR)
    |=> !HOLD_O && !DONE_IRQ_O) else $error("write did not abort");
endmodule // sar_adc_checker
bind sar_adc_ctrl sar_adc_checker u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .HOLD_O(HOLD_O),
  .DAC_CODE_O(DAC_CODE_O), .DONE_IRQ_O(DONE_IRQ_O));
`default_nettype wire

// ===== verif/analog_src.sv
// Analog inputs, comparator and trigger source.
// Assumes the bench sets lvl and trig off the clock edge.
`timescale 1ns/1ns
`default_nettype none
module analog_src (
  input  wire logic [2:0] chan_i,
  input  wire logic [9:0] code_i,
  output logic            comp_o,
  output logic            trig_o
);
  logic [9:0] lvl [8];
  logic       trig;
  initial begin
    trig = 1'b0;
    foreach (lvl[i]) lvl[i] = 10'h155;
  end
  // Levels stay put for a whole conversion
  assign comp_o = (lvl[chan_i] >= code_i);
  assign trig_o = trig;
endmodule // analog_src
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the converter sequencer.
// Assumes analog_src answers the comparator and the trigger.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sar_adc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, comp, trig, hold, done, terr;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, q;
  logic [9:0]  code;
  logic [2:0]  chan;
  int          n_fail = 0, checks_done = 0, c, p[6], k;
  int          lt[6] = '{13, 11, 8, 6, 5, 4};
  int          tc[6] = '{0, 1, 2, 4, 5, 6};
  sar_adc_ctrl u_dut (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TRIGGER_I(trig), .COMP_I(comp),
    .CHANNEL_O(chan), .HOLD_O(hold), .DAC_CODE_O(code), .DONE_IRQ_O(done), .TIME_ERR_O(terr));
  analog_src u_src (.chan_i(chan), .code_i(code), .comp_o(comp), .trig_o(trig));
  initial forever #20 clk = ~clk;
  task automatic chk(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
    // One idle edge keeps the strobe from being lowered and raised in one step
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [15:0] a);
    addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    // Read data stand only in the cycle after the strobe, so take them at its closing edge
    @(posedge clk); q = rdata;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Counts cycles until the done pulse, then steps past it
  task automatic wait_done;
    c = 0;
    while (done !== 1'b1) begin
      @(posedge clk); #1 c++;
      if (c > 400) begin n_fail++; $display("FAIL done timeout"); end_of_test; end
    end
    @(posedge clk); #1;
  endtask
  task automatic count_done(input int n);
    repeat (n) begin @(posedge clk); #1 k += int'(done === 1'b1); end
  endtask
  task automatic t_regs;
    rd_reg(MODE_ADDR); chk("mode reset", 16'h0000, q);
    rd_reg(16'h0000); chk("unmapped", 16'h0000, q);
    $display("t_regs done");
  endtask
  task automatic t_soft;
    u_src.lvl[3] = 10'h2a5;
    wr_reg(CHANNEL_ADDR, 16'h0003);
    chk("channel", 16'h0003, {13'h0000, chan});
    wr_reg(MODE_ADDR, 16'h00b1);
    wait_done; wait_done;
    rd_reg(RESULT_ADDR); chk("result", 16'ha940, q);
    rd_reg(MODE_ADDR); chk("mode", 16'h00b0, q);
    for (int i = 0; i < 6; i++) begin
      wr_reg(MODE_ADDR, 16'h0080 | 16'(tc[i] << 3));
      wait_done; wait_done; p[i] = c;
    end
    for (int i = 0; i < 6; i++) chk("period", 16'(10 * (lt[i] - 4)), 16'(p[i] - p[5]));
    // Channel write in mid conversion restarts a full 48-clock conversion
    repeat (20) @(posedge clk);
    wr_reg(CHANNEL_ADDR, 16'h0003);
    wait_done; chk("abort restart", 16'(CYC_48), 16'(c));
    wr_reg(MODE_ADDR, 16'h0098); #1 chk("time err", 16'h0001, {15'h0, terr});
    wr_reg(MODE_ADDR, 16'h0000);
    k = 0; count_done(300); chk("stopped", 16'h0000, 16'(k));
    $display("t_soft done");
  endtask
  task automatic t_hw;
    for (int e = 0; e < 4; e++) begin
      wr_reg(MODE_ADDR, 16'h00f0 | 16'(e << 1));
      k = 0; #1 u_src.trig = 1'b1; count_done(150);
      u_src.trig = 1'b0; count_done(150);
      chk("hw count", 16'(int'(e[0]) + int'(e[1])), 16'(k));
      @(posedge clk);
    end
    $display("t_hw done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs; t_soft; t_hw;
    end_of_test;
  end
endmodule // tb
`default_nettype wire
